// [pkg/imc_consts.svh]
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH

// register addresses on the host access port
`define IMC_ADDR_CONTROL 24'h801302
`define IMC_ADDR_LINE_LEN 24'h801304
`define IMC_ADDR_PROG_PORT 24'h801306
`define IMC_ADDR_DATA_PORT 24'h801308
`define IMC_ADDR_STATUS 24'h80130A
`define IMC_ADDR_HOFF 24'h801310
`define IMC_ADDR_HEXT 24'h801312
`define IMC_ADDR_VOFF 24'h801314
`define IMC_ADDR_VEXT 24'h801316

// control register fields
`define IMC_CTL_START 0
`define IMC_CTL_FLUSH 1
`define IMC_CTL_SEL_LO 3
`define IMC_CTL_SEL_HI 4
`define IMC_CTL_ALT_SRC 6
`define IMC_CTL_TBUS2 7
`define IMC_CTL_RESET 16'h0000

// status register fields
`define IMC_ST_OVERRUN 0
`define IMC_ST_UNDERRUN 1
`define IMC_ST_EMPTY 2
`define IMC_ST_FULL 3

// stage control bits, active low
`define IMC_SC_DIV 0
`define IMC_SC_CIS 1
`define IMC_SC_LIS 2
`define IMC_SC_IDLE 3'h7

// output buffer: one line of the widest stage line
`define IMC_FIFO_AW 12
`define IMC_FIFO_DEPTH 4096
`define IMC_CNT_W 12

`endif

// [pkg/imc_pkg.sv]
package imc_pkg;
    // pipeline I/O selection, control bits 4:3
    typedef enum logic [1:0] {
        IMC_SEL_EXT = 2'b00,
        IMC_SEL_VIDEO = 2'b01,
        IMC_SEL_CLBUS = 2'b10,
        IMC_SEL_HOST = 2'b11
    } imc_sel_t;

    // region counter phases
    typedef enum logic [1:0] {
        IMC_RG_OFFSET = 2'b00,
        IMC_RG_EXTENT = 2'b01,
        IMC_RG_DONE = 2'b10
    } imc_rg_t;
endpackage

// [pkg/imc_region_if.sv]
`timescale 1ns/1ps
`include "imc_consts.svh"
interface imc_region_if;
    logic hsync;
    logic vsync;
    logic pixEn;
    logic [`IMC_CNT_W-1:0] hOff;
    logic [`IMC_CNT_W-1:0] hExt;
    logic [`IMC_CNT_W-1:0] vOff;
    logic [`IMC_CNT_W-1:0] vExt;
    logic inRegion;
    logic lineFirst;
    modport ctrl (output hsync, vsync, pixEn, hOff, hExt, vOff, vExt,
        input inRegion, lineFirst);
    modport counter (input hsync, vsync, pixEn, hOff, hExt, vOff, vExt,
        output inRegion, lineFirst);
endinterface

// [design/imc_region_counter.sv]
`timescale 1ns/1ps
`include "imc_consts.svh"
module imc_region_counter
    import imc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    imc_region_if.counter rg
);
    logic [`IMC_CNT_W-1:0] hCnt_reg;
    logic [`IMC_CNT_W-1:0] vCnt_reg;
    imc_rg_t hPh_reg;
    imc_rg_t vPh_reg;
    logic [`IMC_CNT_W-1:0] hCntInc;
    logic [`IMC_CNT_W-1:0] vCntInc;
    logic hLast;
    logic vLast;
    logic lineActive;

    // counters count up from minus length; all ones marks the last step
    assign hCntInc = hCnt_reg + `IMC_CNT_W'(1);
    assign vCntInc = vCnt_reg + `IMC_CNT_W'(1);
    assign hLast = &hCnt_reg;
    assign vLast = &vCnt_reg;
    assign lineActive = (vPh_reg == IMC_RG_EXTENT);
    assign rg.inRegion = lineActive && (hPh_reg == IMC_RG_EXTENT) &&
        rg.pixEn;
    assign rg.lineFirst = rg.inRegion && (hCnt_reg == rg.hExt);

    // vertical: offset reloads on each vsync and counts hsyncs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vCnt_reg <= '0;
            vPh_reg <= IMC_RG_DONE;
        end else if (rg.vsync) begin
            vCnt_reg <= rg.vOff;
            vPh_reg <= IMC_RG_OFFSET;
        end else if (rg.hsync) begin
            case (vPh_reg)
                IMC_RG_OFFSET: begin
                    vCnt_reg <= vLast ? rg.vExt : vCntInc;
                    vPh_reg <= vLast ? IMC_RG_EXTENT : IMC_RG_OFFSET;
                end
                IMC_RG_EXTENT: begin
                    vCnt_reg <= vCntInc;
                    vPh_reg <= vLast ? IMC_RG_DONE : IMC_RG_EXTENT;
                end
                default: vPh_reg <= IMC_RG_DONE;
            endcase
        end
    end

    // horizontal: offset from hsync, then extent over valid pixels
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hCnt_reg <= '0;
            hPh_reg <= IMC_RG_DONE;
        end else if (rg.hsync) begin
            hCnt_reg <= rg.hOff;
            hPh_reg <= IMC_RG_OFFSET;
        end else if (rg.pixEn) begin
            case (hPh_reg)
                IMC_RG_OFFSET: begin
                    hCnt_reg <= hLast ? rg.hExt : hCntInc;
                    hPh_reg <= hLast ? IMC_RG_EXTENT : IMC_RG_OFFSET;
                end
                IMC_RG_EXTENT: begin
                    hCnt_reg <= hCntInc;
                    hPh_reg <= hLast ? IMC_RG_DONE : IMC_RG_EXTENT;
                end
                default: hPh_reg <= IMC_RG_DONE;
            endcase
        end
    end
endmodule

// [design/imc_top.sv]
`timescale 1ns/1ps
`include "imc_consts.svh"
module imc_top
    import imc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [23:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic [7:0] stageData,
    output logic [2:0] stageCtl,
    output logic stageAdvance,
    input wire logic [7:0] stageRetData,
    input wire logic [2:0] stageRetCtl,
    input wire logic [7:0] extInData,
    input wire logic [2:0] extInCtl,
    input wire logic extInValid,
    output logic [7:0] extOutData,
    output logic [2:0] extOutCtl,
    input wire logic [7:0] vidData,
    input wire logic [7:0] vidAltData,
    input wire logic vidHsync1N,
    input wire logic vidVsync1N,
    input wire logic vidHsync2N,
    input wire logic vidVsync2N,
    output logic [7:0] vidOutData,
    output logic vidOutValid
);
    logic [15:0] control_reg;
    logic [15:0] lineLen_reg;
    logic [`IMC_CNT_W-1:0] hOff_reg, hExt_reg, vOff_reg, vExt_reg;
    logic overrun_reg, underrun_reg;
    logic [`IMC_CNT_W-1:0] lineCnt_reg;
    logic lineOpen_reg;
    logic advD_reg, advImg_reg, imgRet_reg, imgHeld_reg;
    logic [7:0] fifo_mem [`IMC_FIFO_DEPTH];
    logic [`IMC_FIFO_AW:0] wrPtr_reg, rdPtr_reg;
    logic [7:0] progRet_reg;
    logic [2:0] progRetCtl_reg;
    // two-stage synchronisers for pin inputs
    logic [7:0] eD1, eD2, vD1, vD2, aD1, aD2;
    logic [2:0] eC1, eC2;
    logic eV1, eV2;
    logic [3:0] sy1, sy2, syPrev_reg;
    imc_region_if rg ();

    imc_sel_t sel;
    logic wrCtl, wrData, wrProg, rdData, flushFill;
    logic fifoEmpty, fifoFull, pushImg, imgAdv, lineStart;
    logic hsyncSel, vsyncSel;
    logic [7:0] vidPix;
    logic [`IMC_CNT_W-1:0] lineCntInc;
    logic [15:0] statusWord;

    function automatic logic hitAddr(input logic [23:0] a,
        input logic [23:0] ref_a);
        hitAddr = (a == ref_a);
    endfunction

    // register decode and path selection
    assign sel = imc_sel_t'(control_reg[`IMC_CTL_SEL_HI:`IMC_CTL_SEL_LO]);
    assign wrCtl = regWr && hitAddr(regAddr, `IMC_ADDR_CONTROL);
    assign wrData = regWr && hitAddr(regAddr, `IMC_ADDR_DATA_PORT) &&
        (sel == IMC_SEL_HOST);
    assign wrProg = regWr && hitAddr(regAddr, `IMC_ADDR_PROG_PORT);
    assign rdData = regRd && hitAddr(regAddr, `IMC_ADDR_DATA_PORT);
    assign fifoEmpty = (wrPtr_reg == rdPtr_reg);
    assign fifoFull = (wrPtr_reg[`IMC_FIFO_AW] != rdPtr_reg[`IMC_FIFO_AW])
        && (wrPtr_reg[`IMC_FIFO_AW-1:0] == rdPtr_reg[`IMC_FIFO_AW-1:0]);
    // flush feeds idle pixels in host select when neither port is written and the buffer is not full
    assign flushFill = control_reg[`IMC_CTL_FLUSH] && !wrData && !wrProg &&
        !fifoFull && (sel == IMC_SEL_HOST);
    assign imgAdv = wrData || flushFill;
    assign lineCntInc = lineCnt_reg + `IMC_CNT_W'(1);
    assign lineStart = wrData && !lineOpen_reg;
    assign pushImg = imgHeld_reg;
    assign hsyncSel = control_reg[`IMC_CTL_TBUS2] ? !sy2[2] : !sy2[0];
    assign vsyncSel = control_reg[`IMC_CTL_TBUS2] ? !sy2[3] : !sy2[1];
    // source pick after both pixel paths are synchronised
    assign vidPix = control_reg[`IMC_CTL_ALT_SRC] ? aD2 : vD2;
    assign rg.hsync = hsyncSel && syPrev_reg[0];
    assign rg.vsync = vsyncSel && syPrev_reg[1];
    assign rg.pixEn = (sel == IMC_SEL_VIDEO) || (sel == IMC_SEL_CLBUS);
    assign rg.hOff = hOff_reg;
    assign rg.hExt = hExt_reg;
    assign rg.vOff = vOff_reg;
    assign rg.vExt = vExt_reg;
    assign statusWord = {12'h000, fifoFull, fifoEmpty, underrun_reg,
        overrun_reg};

    imc_region_counter u_region (
        .clk(clk),
        .reset_n(reset_n),
        .rg(rg.counter)
    );

    // pin synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {eD1, eD2, vD1, vD2, aD1, aD2} <= '0;
            {eC1, eC2} <= {`IMC_SC_IDLE, `IMC_SC_IDLE};
            {eV1, eV2} <= '0;
            {sy1, sy2} <= 8'hFF;
        end else begin
            eD1 <= extInData;
            eD2 <= eD1;
            eC1 <= extInCtl;
            eC2 <= eC1;
            eV1 <= extInValid;
            eV2 <= eV1;
            vD1 <= vidData;
            vD2 <= vD1;
            aD1 <= vidAltData;
            aD2 <= aD1;
            sy1 <= {vidVsync2N, vidHsync2N, vidVsync1N, vidHsync1N};
            sy2 <= sy1;
        end
    end

    // sync edge memory: previous level was inactive high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syPrev_reg <= 4'h0;
        end else begin
            syPrev_reg <= {2'b00, !vsyncSel, !hsyncSel};
        end
    end

    // software-written registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg <= `IMC_CTL_RESET;
            lineLen_reg <= 16'h0000;
            {hOff_reg, hExt_reg, vOff_reg, vExt_reg} <= '0;
        end else if (regWr) begin
            if (wrCtl) control_reg <= regWrData;
            if (hitAddr(regAddr, `IMC_ADDR_LINE_LEN)) lineLen_reg <= regWrData;
            if (hitAddr(regAddr, `IMC_ADDR_HOFF)) hOff_reg <= regWrData[11:0];
            if (hitAddr(regAddr, `IMC_ADDR_HEXT)) hExt_reg <= regWrData[11:0];
            if (hitAddr(regAddr, `IMC_ADDR_VOFF)) vOff_reg <= regWrData[11:0];
            if (hitAddr(regAddr, `IMC_ADDR_VEXT)) vExt_reg <= regWrData[11:0];
        end
    end

    // host line counter, restarted by a start write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineCnt_reg <= '0;
            lineOpen_reg <= 1'b0;
        end else if (wrCtl && regWrData[`IMC_CTL_START]) begin
            lineOpen_reg <= 1'b0;
        end else if (wrData) begin
            lineCnt_reg <= lineStart ? lineLen_reg[11:0] + `IMC_CNT_W'(1)
                : lineCntInc;
            lineOpen_reg <= lineStart ? !(&lineLen_reg[11:0])
                : !(&lineCnt_reg);
        end
    end

    // drive the stage cascade from the selected source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stageData <= 8'h00;
            stageCtl <= `IMC_SC_IDLE;
            stageAdvance <= 1'b0;
            advImg_reg <= 1'b0;
        end else begin
            case (sel)
                IMC_SEL_HOST: begin
                    stageAdvance <= imgAdv || wrProg;
                    advImg_reg <= imgAdv;
                    stageData <= wrProg ? regWrData[7:0]
                        : (wrData ? regWrData[7:0] : 8'h00);
                    // host pixels are valid, flush fill pixels are not
                    stageCtl <= wrProg ? regWrData[10:8]
                        : {!lineStart, 1'b1, !wrData};
                end
                IMC_SEL_EXT: begin
                    stageAdvance <= eV2;
                    advImg_reg <= 1'b0;
                    stageData <= eD2;
                    stageCtl <= eC2;
                end
                default: begin
                    stageAdvance <= 1'b1;
                    advImg_reg <= 1'b0;
                    stageData <= vidPix;
                    stageCtl <= {!rg.lineFirst, 1'b1, !rg.inRegion};
                end
            endcase
        end
    end

    // stage return: programming port register and far-side outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            advD_reg <= 1'b0;
            imgRet_reg <= 1'b0;
            imgHeld_reg <= 1'b0;
            progRet_reg <= 8'h00;
            progRetCtl_reg <= `IMC_SC_IDLE;
            extOutData <= 8'h00;
            extOutCtl <= `IMC_SC_IDLE;
            vidOutData <= 8'h00;
            vidOutValid <= 1'b0;
        end else begin
            advD_reg <= stageAdvance;
            // image pixels follow the port capture by one more cycle
            imgRet_reg <= advImg_reg;
            imgHeld_reg <= imgRet_reg;
            if (advD_reg) begin
                progRet_reg <= stageRetData;
                progRetCtl_reg <= stageRetCtl;
            end
            extOutData <= stageRetData;
            extOutCtl <= stageRetCtl;
            vidOutData <= stageRetData;
            vidOutValid <= rg.pixEn && !stageRetCtl[`IMC_SC_DIV];
        end
    end

    // output buffer write side, one cycle behind the programming port
    always_ff @(posedge clk) begin
        if (pushImg && !fifoFull)
            fifo_mem[wrPtr_reg[`IMC_FIFO_AW-1:0]] <= progRet_reg;
    end

    // buffer pointers and sticky errors; a new event beats the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            overrun_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            if (pushImg && !fifoFull) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (rdData && !fifoEmpty) rdPtr_reg <= rdPtr_reg + 1'b1;
            if (pushImg && fifoFull) overrun_reg <= 1'b1;
            else if (regWr && hitAddr(regAddr, `IMC_ADDR_STATUS) &&
                regWrData[`IMC_ST_OVERRUN]) overrun_reg <= 1'b0;
            if (rdData && fifoEmpty) underrun_reg <= 1'b1;
            else if (regWr && hitAddr(regAddr, `IMC_ADDR_STATUS) &&
                regWrData[`IMC_ST_UNDERRUN]) underrun_reg <= 1'b0;
        end
    end

    // read data, registered; unmapped addresses read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `IMC_ADDR_CONTROL: regRdData <= control_reg;
                `IMC_ADDR_LINE_LEN: regRdData <= lineLen_reg;
                `IMC_ADDR_PROG_PORT: regRdData <= {5'h00, progRetCtl_reg,
                    progRet_reg};
                `IMC_ADDR_DATA_PORT: regRdData <= fifoEmpty ? 16'h0000
                    : {8'h00, fifo_mem[rdPtr_reg[`IMC_FIFO_AW-1:0]]};
                `IMC_ADDR_STATUS: regRdData <= statusWord;
                `IMC_ADDR_HOFF: regRdData <= {4'h0, hOff_reg};
                `IMC_ADDR_HEXT: regRdData <= {4'h0, hExt_reg};
                `IMC_ADDR_VOFF: regRdData <= {4'h0, vOff_reg};
                `IMC_ADDR_VEXT: regRdData <= {4'h0, vExt_reg};
                default: regRdData <= 16'h0000;
            endcase
        end
    end
endmodule

// [dv/imc_stage_model.sv]
`timescale 1ns/1ps
module imc_stage_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] stageData,
    input wire logic [2:0] stageCtl,
    input wire logic stageAdvance,
    output logic [7:0] stageRetData,
    output logic [2:0] stageRetCtl
);
    // one bypassed stage: moves a pixel only when advanced
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stageRetData <= 8'h00;
            stageRetCtl <= 3'h7;
        end else if (stageAdvance) begin
            stageRetData <= stageData;
            stageRetCtl <= stageCtl;
        end
    end
endmodule

// [dv/imc_top_props.sv]
`timescale 1ns/1ps
`include "imc_consts.svh"
module imc_top_props
    import imc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [23:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic [7:0] stageData,
    input wire logic [2:0] stageCtl,
    input wire logic stageAdvance
);
    logic [15:0] ctl_reg, len_reg, pix_reg, pix_next;
    // decode of host accesses; data and programming writes need host select and flush off
    wire hostSel = ctl_reg[4:3] == IMC_SEL_HOST;
    wire flushOn = ctl_reg[`IMC_CTL_FLUSH];
    wire ctlWr = regWr && regAddr == `IMC_ADDR_CONTROL;
    wire dataWr = regWr && regAddr == `IMC_ADDR_DATA_PORT && hostSel &&
        !flushOn;
    wire progWr = regWr && regAddr == `IMC_ADDR_PROG_PORT && hostSel &&
        !flushOn;
    wire hostIdle = hostSel && !flushOn && !regWr;
    wire [7:0] wrByte = regWrData[7:0];
    wire [2:0] wrCtl = regWrData[10:8];
    wire [15:0] pixInc = pix_reg + 16'h0001;
    wire mapped = regAddr inside {`IMC_ADDR_CONTROL, `IMC_ADDR_LINE_LEN,
        `IMC_ADDR_PROG_PORT, `IMC_ADDR_DATA_PORT, `IMC_ADDR_STATUS,
        `IMC_ADDR_HOFF, `IMC_ADDR_HEXT, `IMC_ADDR_VOFF, `IMC_ADDR_VEXT};
    assign pix_next = (ctlWr && regWrData[`IMC_CTL_START]) ? 16'h0000 :
        !dataWr ? pix_reg : (pixInc == 16'h0000 - len_reg) ? 16'h0000 : pixInc;

    // shadow of control, line length and pixel position in the line
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_reg <= `IMC_CTL_RESET;
            len_reg <= 16'h0000;
            pix_reg <= 16'h0000;
        end else begin
            if (ctlWr) ctl_reg <= regWrData;
            if (regWr && regAddr == `IMC_ADDR_LINE_LEN) len_reg <= regWrData;
            pix_reg <= pix_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence pixOut;
        stageAdvance && !stageCtl[`IMC_SC_DIV] && stageData == $past(wrByte);
    endsequence
    sequence cmdOut;
        stageAdvance && stageCtl == $past(wrCtl) && stageData == $past(wrByte);
    endsequence

    a_reset_idle: assert property (
        $rose(reset_n) |-> stageCtl == `IMC_SC_IDLE && !stageAdvance)
        else $error("stage link busy after reset");
    a_host_pixel: assert property (dataWr |=> pixOut)
        else $error("host pixel not sent to stages");
    a_line_strobe: assert property (
        dataWr |=> stageCtl[`IMC_SC_LIS] == ($past(pix_reg) != 16'h0000))
        else $error("line start strobe misplaced");
    a_prog_word: assert property (progWr |=> cmdOut)
        else $error("command word not sent to stages");
    a_host_quiet: assert property (hostIdle |=> !stageAdvance)
        else $error("stage advanced without a host pixel");
    a_ctl_read: assert property (
        regRd && regAddr == `IMC_ADDR_CONTROL |=>
        regRdData[15:1] == ctl_reg[15:1])
        else $error("control read back wrong");
    a_read_holds: assert property (!regRd |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        regRd && !mapped |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind imc_top imc_top_props u_props (.clk, .reset_n, .regAddr, .regWr, .regRd,
    .regWrData, .regRdData, .stageData, .stageCtl, .stageAdvance);

// [dv/imc_top_test.sv]
`timescale 1ns/1ps
`include "imc_consts.svh"
module imc_top_test;
    logic clk, reset_n, regWr, regRd, extInValid, vidOutValid, stageAdvance;
    logic vidHsync1N, vidVsync1N, vidHsync2N, vidVsync2N, vidOn;
    logic [23:0] regAddr;
    logic [15:0] regWrData, regRdData, lfsrVal, rdVal, progWord;
    logic [7:0] stageData, stageRetData, extInData, extOutData;
    logic [7:0] vidData, vidAltData, vidOutData;
    logic [2:0] stageCtl, stageRetCtl, extInCtl, extOutCtl;
    logic [7:0] pixQ[$];
    int num_errors, total_checks, vidSeen, hit;

    imc_top dut (.clk, .reset_n, .regAddr, .regWr, .regRd, .regWrData,
        .regRdData, .stageData, .stageCtl, .stageAdvance, .stageRetData,
        .stageRetCtl, .extInData, .extInCtl, .extInValid, .extOutData,
        .extOutCtl, .vidData, .vidAltData, .vidHsync1N, .vidVsync1N,
        .vidHsync2N, .vidVsync2N, .vidOutData, .vidOutValid);
    imc_stage_model u_stage (.clk, .reset_n, .stageData, .stageCtl,
        .stageAdvance, .stageRetData, .stageRetCtl);

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [15:0] nextRnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    // host register cycles; a write leaves its strobe up for back to back use
    task wr(input logic [23:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regRd <= 1'b0;
        regWr <= 1'b1;
        @(posedge clk);
    endtask
    task rd(input logic [23:0] a);
        regAddr <= a;
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        rdVal = regRdData;
    endtask
    task idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // every video pixel out must come from the alternate source
    always @(negedge clk) begin
        if (vidOn && vidOutValid === 1'b1) begin
            vidSeen++;
            chk({8'h00, vidOutData}, 16'h005A);
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("BAD %0t run did not finish", $time);
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        {regWr, regRd, extInValid, vidOn} = 4'h0;
        regAddr = 24'h000000;
        regWrData = 16'h0000;
        {extInData, extInCtl} = 11'h000;
        vidData = 8'hA5;
        vidAltData = 8'h5A;
        {vidHsync1N, vidVsync1N, vidHsync2N, vidVsync2N} = 4'hF;
        lfsrVal = 16'h2E10;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`IMC_ADDR_CONTROL);
        chk(rdVal, `IMC_CTL_RESET);
        rd(24'h801320);
        // host circulation: fill the buffer past full, then drain it
        wr(`IMC_ADDR_LINE_LEN, 16'hFFFB);
        wr(`IMC_ADDR_CONTROL, 16'h0018);
        wr(`IMC_ADDR_CONTROL, 16'h0019);
        for (int i = 0; i < 4098; i++) begin
            lfsrVal = nextRnd(lfsrVal);
            if (pixQ.size() < `IMC_FIFO_DEPTH) pixQ.push_back(lfsrVal[7:0]);
            wr(`IMC_ADDR_DATA_PORT, lfsrVal);
        end
        idle(4);
        rd(`IMC_ADDR_STATUS);
        chk(rdVal & 16'h000F, 16'h0009);
        wr(`IMC_ADDR_STATUS, 16'h0003);
        idle(1);
        rd(`IMC_ADDR_STATUS);
        chk(rdVal & 16'h000F, 16'h0008);
        while (pixQ.size() > 0) begin
            rd(`IMC_ADDR_DATA_PORT);
            chk(rdVal & 16'h00FF, {8'h00, pixQ.pop_front()});
        end
        rd(`IMC_ADDR_STATUS);
        chk(rdVal & 16'h000F, 16'h0004);
        rd(`IMC_ADDR_DATA_PORT);
        chk(rdVal, 16'h0000);
        rd(`IMC_ADDR_STATUS);
        chk(rdVal & 16'h000F, 16'h0006);
        // command word round trip through the programming port
        progWord = {8'h05, lfsrVal[7:0]};
        wr(`IMC_ADDR_PROG_PORT, progWord);
        idle(3);
        rd(`IMC_ADDR_PROG_PORT);
        chk(rdVal & 16'h07FF, progWord);
        // flush pushes idle pixels into the stages
        wr(`IMC_ADDR_CONTROL, 16'h001B);
        idle(1);
        hit = 0;
        repeat (20) begin
            @(negedge clk);
            if (stageAdvance === 1'b1 && stageCtl[`IMC_SC_DIV] === 1'b1)
                hit = 1;
        end
        @(posedge clk);
        chk(hit[15:0], 16'h0001);
        rd(`IMC_ADDR_STATUS);
        chk(rdVal & 16'h0004, 16'h0000);
        wr(`IMC_ADDR_CONTROL, 16'h0018);
        // external connector path
        wr(`IMC_ADDR_CONTROL, 16'h0000);
        idle(1);
        for (int i = 0; i < 4; i++) begin
            lfsrVal = nextRnd(lfsrVal);
            extInData <= lfsrVal[7:0];
            extInCtl <= lfsrVal[10:8];
            extInValid <= 1'b1;
            repeat (3) @(posedge clk);
            extInValid <= 1'b0;
            hit = 0;
            repeat (12) begin
                @(negedge clk);
                if (extOutData === lfsrVal[7:0] && extOutCtl === lfsrVal[10:8])
                    hit = 1;
            end
            @(posedge clk);
            chk(hit[15:0], 16'h0001);
        end
        // video path on timing bus two with the alternate source
        wr(`IMC_ADDR_HOFF, 16'hFFFD);
        wr(`IMC_ADDR_HEXT, 16'hFFFC);
        wr(`IMC_ADDR_VOFF, 16'hFFFE);
        wr(`IMC_ADDR_VEXT, 16'hFFFE);
        wr(`IMC_ADDR_CONTROL, 16'h00C8);
        rd(`IMC_ADDR_HEXT);
        chk(rdVal & 16'h0FFF, 16'h0FFC);
        // let the connector path drain out of the stage return first
        idle(3);
        vidOn = 1'b1;
        vidVsync2N <= 1'b0;
        @(posedge clk);
        vidVsync2N <= 1'b1;
        repeat (6) begin
            vidHsync2N <= 1'b0;
            @(posedge clk);
            vidHsync2N <= 1'b1;
            repeat (30) @(posedge clk);
        end
        chk(vidSeen[15:0], 16'h0008);
        summarize();
    end
endmodule
